// ==== design/vrcl_defines.vh ====
`ifndef VRCL_DEFINES_VH
`define VRCL_DEFINES_VH
// =============================================
// Register command codes
`define VRCL_A_CFG3 8'h45
`define VRCL_A_APPID 8'h46
`define VRCL_A_REV 8'h47
`define VRCL_A_IOC 8'h4a
`define VRCL_A_OFS1 8'h4c
`define VRCL_A_OFS2 8'h4d
`define VRCL_A_OFS3 8'h4e
`define VRCL_A_OTW 8'h51
`define VRCL_A_VINOV 8'h55
`define VRCL_A_VINUV 8'h58
// =============================================
// Writable masks and reset values
`define VRCL_M_CFG3 16'h07ff
`define VRCL_M_IOC 16'h03ff
`define VRCL_M_OFS1 16'h7fff
`define VRCL_M_OTW 16'h00ff
`define VRCL_M_MANT 16'h00ff
`define VRCL_EXP_FIXED 5'h1d
`define VRCL_RST_WORD 16'h0000
// =============================================
// Field positions in the config word
`define VRCL_B_SS 10
`define VRCL_B_LGEN 9
`define VRCL_F_LG_HI 8
`define VRCL_F_LG_LO 6
`define VRCL_B_TLV 5
`define VRCL_B_CLAMP 4
`define VRCL_B_TSIGN 3
`define VRCL_B_BOOTSEL 2
`define VRCL_F_TBL_HI 1
`define VRCL_F_TBL_LO 0
// =============================================
// Gains, tables and thresholds
`define VRCL_LG_MUL 10'h020
`define VRCL_LG_ADD 10'h01f
`define VRCL_CONST_GAIN 10'h01f
`define VRCL_ERR_50MV 12'h032
`define VRCL_TBL0_STEP 12'h064
`define VRCL_TBL1_STEP 12'h032
`define VRCL_TBL2_STEP 12'h0c8
`define VRCL_TBL3_STEP 12'h064
`define VRCL_TBL0_MAX 12'h5dc
`define VRCL_TBL1_MAX 12'h60e
`define VRCL_TBL2_MAX 12'hbb8
`define VRCL_TBL3_MAX 12'hc1c
`define VRCL_TON_MIN_NS 12'h05a
`define VRCL_TON_MAX_NS 12'h460
`define VRCL_PIN_LOW 2'h0
`define VRCL_PIN_HIZ 2'h1
`define VRCL_PIN_HIGH 2'h2
`define VRCL_SRC_CMD 2'h0
`define VRCL_SRC_MAX 2'h1
`define VRCL_SRC_MIN 2'h2
`define VRCL_SRC_STRAP 2'h3
`endif

// ==== design/vrcl_word_reg.v ====
`timescale 1ns/10ps
`include "vrcl_defines.vh"
// =============================================
// Masked word register, read data registered
module vrcl_word_reg #(
   parameter [15:0] MASK = 16'hffff,
   parameter [15:0] FIXED = 16'h0000
) (
   input wire clk_i,
   input wire rst_i,
   input wire we_i,
   input wire [15:0] wdata_i,
   output reg [15:0] q_o
);
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_o <= `VRCL_RST_WORD | FIXED;
      end else if (we_i) begin
         q_o <= (wdata_i & MASK) | FIXED;
      end
   end
endmodule

// ==== design/vrcl_regs.v ====
`timescale 1ns/10ps
`include "vrcl_defines.vh"
module vrcl_regs (
   input wire clk_i,
   input wire rst_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] addr_i,
   input wire [15:0] wdata_i,
   output reg [15:0] rdata_o,
   output reg ack_o,
   input wire [1:0] voltage_id_pin_i,
   input wire softstart_active_i,
   input wire softstart_done_i,
   input wire [11:0] phase_err_mv_i,
   input wire [4:0] strap_level_i,
   input wire [11:0] computed_ontime_ns_i,
   input wire [11:0] min_ontime_ns_i,
   input wire total_current_res_i,
   input wire sample_i,
   input wire [10:0] iout_amps_i,
   input wire [8:0] temp_deg_i,
   input wire [8:0] vin_eighths_i,
   output reg balance_hold_o,
   output reg [9:0] balance_gain_o,
   output reg [1:0] target_src_o,
   output reg [11:0] boot_mv_o,
   output reg [11:0] ontime_ns_o,
   output reg ontime_range_err_o,
   output reg [4:0] phase_two_offset_o,
   output reg [4:0] phase_three_offset_o,
   output reg [4:0] phase_four_offset_o,
   output reg temp_offset_sign_o,
   output reg output_current_status_o,
   output reg temp_status_o,
   output reg input_uv_status_o,
   output reg shutdown_o
);
   // =============================================
   // Register storage
   wire [15:0] cfg_q;
   wire [15:0] appid_q;
   wire [15:0] rev_q;
   wire [15:0] ioc_q;
   wire [15:0] ofs1_q;
   wire [15:0] otw_q;
   wire [15:0] vinov_q;
   wire [15:0] vinuv_q;
   // =============================================
   // Decode helpers
   function hit;
      input [7:0] a;
      input [7:0] code;
      begin
         hit = (a == code);
      end
   endfunction
   function [8:0] low_byte9;
      input [15:0] w;
      begin
         low_byte9 = {1'b0, w[7:0]};
      end
   endfunction
   function [9:0] gain_of;
      input [2:0] fld;
      begin
         gain_of = {7'h00, fld} * `VRCL_LG_MUL + `VRCL_LG_ADD;
      end
   endfunction
   wire wr_cfg = wr_i && hit(addr_i, `VRCL_A_CFG3);
   wire wr_appid = wr_i && hit(addr_i, `VRCL_A_APPID);
   wire wr_rev = wr_i && hit(addr_i, `VRCL_A_REV);
   wire wr_ioc = wr_i && hit(addr_i, `VRCL_A_IOC);
   wire wr_ofs1 = wr_i && hit(addr_i, `VRCL_A_OFS1);
   wire wr_otw = wr_i && hit(addr_i, `VRCL_A_OTW);
   wire wr_vinov = wr_i && hit(addr_i, `VRCL_A_VINOV);
   wire wr_vinuv = wr_i && hit(addr_i, `VRCL_A_VINUV);
   localparam [15:0] EXP_WORD = {`VRCL_EXP_FIXED, 11'h000};
   // Upper config bits belong to another block and read zero here
   vrcl_word_reg #(.MASK(`VRCL_M_CFG3)) u_cfg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_cfg),
      .wdata_i(wdata_i),
      .q_o(cfg_q)
   );
   vrcl_word_reg #(.MASK(16'hffff)) u_appid (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_appid),
      .wdata_i(wdata_i),
      .q_o(appid_q)
   );
   vrcl_word_reg #(.MASK(16'hffff)) u_rev (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_rev),
      .wdata_i(wdata_i),
      .q_o(rev_q)
   );
   vrcl_word_reg #(.MASK(`VRCL_M_IOC)) u_ioc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_ioc),
      .wdata_i(wdata_i),
      .q_o(ioc_q)
   );
   vrcl_word_reg #(.MASK(`VRCL_M_OFS1)) u_ofs1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_ofs1),
      .wdata_i(wdata_i),
      .q_o(ofs1_q)
   );
   vrcl_word_reg #(.MASK(`VRCL_M_OTW)) u_otw (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_otw),
      .wdata_i(wdata_i),
      .q_o(otw_q)
   );
   vrcl_word_reg #(.MASK(`VRCL_M_MANT), .FIXED(EXP_WORD)) u_vinov (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_vinov),
      .wdata_i(wdata_i),
      .q_o(vinov_q)
   );
   vrcl_word_reg #(.MASK(`VRCL_M_MANT), .FIXED(EXP_WORD)) u_vinuv (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_vinuv),
      .wdata_i(wdata_i),
      .q_o(vinuv_q)
   );
   // =============================================
   // Read path, unmapped and empty offset words read zero
   reg [15:0] rd_mux;
   always @* begin
      case (addr_i)
         `VRCL_A_CFG3: rd_mux = cfg_q;
         `VRCL_A_APPID: rd_mux = appid_q;
         `VRCL_A_REV: rd_mux = rev_q;
         `VRCL_A_IOC: rd_mux = ioc_q;
         `VRCL_A_OFS1: rd_mux = ofs1_q;
         `VRCL_A_OTW: rd_mux = otw_q;
         `VRCL_A_VINOV: rd_mux = vinov_q;
         `VRCL_A_VINUV: rd_mux = vinuv_q;
         `VRCL_A_OFS2: rd_mux = 16'h0000;
         `VRCL_A_OFS3: rd_mux = 16'h0000;
         default: rd_mux = 16'h0000;
      endcase
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
         ack_o <= 1'b0;
      end else begin
         ack_o <= rd_i | wr_i;
         // Same-cycle write and read returns the old word
         if (rd_i) begin
            rdata_o <= rd_mux;
         end
      end
   end
   // =============================================
   // Helpers
   function [11:0] boot_level;
      input [1:0] tbl;
      input [4:0] lvl;
      reg [16:0] v;
      reg [11:0] lim;
      begin
         v = 17'h00000;
         lim = 12'h000;
         case (tbl)
            2'h0: begin
               v = lvl * `VRCL_TBL0_STEP;
               lim = `VRCL_TBL0_MAX;
            end
            2'h1: begin
               v = lvl * `VRCL_TBL1_STEP;
               lim = `VRCL_TBL1_MAX;
            end
            2'h2: begin
               v = lvl * `VRCL_TBL2_STEP;
               lim = `VRCL_TBL2_MAX;
            end
            default: begin
               v = lvl * `VRCL_TBL3_STEP;
               lim = `VRCL_TBL3_MAX;
            end
         endcase
         // Strap codes past the table top saturate
         boot_level = (v > {5'h00, lim}) ? lim : v[11:0];
      end
   endfunction
   // =============================================
   // Control decode
   wire [2:0] lg_field = cfg_q[`VRCL_F_LG_HI:`VRCL_F_LG_LO];
   wire [9:0] large_gain = gain_of(lg_field);
   wire [1:0] tbl_sel = cfg_q[`VRCL_F_TBL_HI:`VRCL_F_TBL_LO];
   wire [11:0] clamped_ton =
      (computed_ontime_ns_i < min_ontime_ns_i) ?
      min_ontime_ns_i : computed_ontime_ns_i;
   reg [1:0] src_d;
   always @* begin
      // Strap boot holds until soft start completes
      if (cfg_q[`VRCL_B_BOOTSEL] && !softstart_done_i) begin
         src_d = `VRCL_SRC_STRAP;
      end else begin
         src_d = `VRCL_SRC_CMD;
      end
      if (cfg_q[`VRCL_B_TLV]) begin
         case (voltage_id_pin_i)
            `VRCL_PIN_HIGH: src_d = `VRCL_SRC_MAX;
            `VRCL_PIN_LOW: src_d = `VRCL_SRC_MIN;
            // Pin code 3 floats, so it is taken as hi-z
            default: src_d = src_d;
         endcase
      end
   end
   // Current limit in amps; 2A steps double the threshold
   wire [10:0] ioc_amps = total_current_res_i ?
      {ioc_q[9:0], 1'b0} : {1'b0, ioc_q[9:0]};
   // =============================================
   // Output registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         balance_hold_o <= 1'b0;
         balance_gain_o <= `VRCL_CONST_GAIN;
         target_src_o <= `VRCL_SRC_CMD;
         boot_mv_o <= 12'h000;
         ontime_ns_o <= 12'h000;
         ontime_range_err_o <= 1'b0;
         phase_two_offset_o <= 5'h00;
         phase_three_offset_o <= 5'h00;
         phase_four_offset_o <= 5'h00;
         temp_offset_sign_o <= 1'b0;
         output_current_status_o <= 1'b0;
         temp_status_o <= 1'b0;
         input_uv_status_o <= 1'b0;
         shutdown_o <= 1'b0;
      end else begin
         balance_hold_o <= softstart_active_i &&
            !cfg_q[`VRCL_B_SS];
         if (cfg_q[`VRCL_B_LGEN] && phase_err_mv_i > `VRCL_ERR_50MV) begin
            balance_gain_o <= large_gain;
         end else begin
            balance_gain_o <= `VRCL_CONST_GAIN;
         end
         target_src_o <= src_d;
         boot_mv_o <= boot_level(tbl_sel, strap_level_i);
         if (cfg_q[`VRCL_B_CLAMP]) begin
            ontime_ns_o <= clamped_ton;
            ontime_range_err_o <= 1'b0;
         end else begin
            ontime_ns_o <= computed_ontime_ns_i;
            // Unclamped on time outside range risks overflow
            ontime_range_err_o <=
               (computed_ontime_ns_i < `VRCL_TON_MIN_NS) ||
               (computed_ontime_ns_i > `VRCL_TON_MAX_NS);
         end
         phase_two_offset_o <= ofs1_q[4:0];
         phase_three_offset_o <= ofs1_q[9:5];
         phase_four_offset_o <= ofs1_q[14:10];
         temp_offset_sign_o <= cfg_q[`VRCL_B_TSIGN];
         if (sample_i) begin
            output_current_status_o <= iout_amps_i > ioc_amps;
            temp_status_o <= temp_deg_i > low_byte9(otw_q);
            input_uv_status_o <=
               vin_eighths_i < low_byte9(vinuv_q);
            // Shutdown latches until reset
            if (vin_eighths_i > low_byte9(vinov_q)) begin
               shutdown_o <= 1'b1;
            end
         end
      end
   end
endmodule

// ==== testbench/vrcl_pin_drv.sv ====
`timescale 1ns/10ps
// =====
// Voltage-id pin driver
module vrcl_pin_drv (
   input wire [1:0] level_i,
   output logic [1:0] voltage_id_pin_o
);
   // Code 3 is an undriven pin, seen as float
   assign voltage_id_pin_o = level_i;
endmodule

// ==== testbench/vrcl_regs_chk.sv ====
`timescale 1ns/10ps
module vrcl_regs_chk (
   input wire clk_i,
   input wire rst_i,
   input wire wr_i,
   input wire rd_i,
   input wire ack_o,
   input wire softstart_active_i,
   input wire [11:0] phase_err_mv_i,
   input wire [11:0] computed_ontime_ns_i,
   input wire sample_i,
   input wire [9:0] balance_gain_o,
   input wire balance_hold_o,
   input wire ontime_range_err_o,
   input wire output_current_status_o,
   input wire temp_status_o,
   input wire input_uv_status_o,
   input wire shutdown_o
);
   // =====
   // Port relations
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property ((wr_i || rd_i) |=> ack_o)
      else $error("ack missing");
   a_ack_cause: assert property (ack_o |-> $past(wr_i || rd_i))
      else $error("ack without request");
   a_gain_form: assert property (balance_gain_o[4:0] == 5'h1f)
      else $error("gain form wrong");
   a_gain_small: assert property
      ($past(phase_err_mv_i) <= 12'h032 |-> balance_gain_o == 10'h01f)
      else $error("large gain on small error");
   a_hold_cause: assert property
      (!$past(softstart_active_i) |-> !balance_hold_o)
      else $error("hold outside soft start");
   a_shut_sticky: assert property (shutdown_o |=> shutdown_o)
      else $error("shutdown released");
   a_shut_cause: assert property ($rose(shutdown_o) |-> $past(sample_i))
      else $error("shutdown without sample");
   a_status_stable: assert property (!$past(sample_i) |->
      $stable(output_current_status_o) && $stable(temp_status_o)
      && $stable(input_uv_status_o))
      else $error("status moved without sample");
   a_ontime_ok: assert property
      ($past(computed_ontime_ns_i) inside {[12'h05a:12'h460]}
      |-> !ontime_range_err_o)
      else $error("range error in range");
   c_read: cover property (ack_o && $past(rd_i));
   c_shut: cover property ($rose(shutdown_o));
   c_ioc: cover property ($rose(output_current_status_o));
endmodule

// ==== testbench/vrcl_regs_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin \
   tests_run++; \
   if ((a) !== (e)) begin \
      fails++; \
      $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); \
   end \
end
module vrcl_regs_tb;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sample_i = 0;
   logic softstart_active_i = 0, softstart_done_i = 0;
   logic total_current_res_i = 0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000, rd;
   logic [11:0] phase_err_mv_i = 12'h000, computed_ontime_ns_i = 12'h000;
   logic [11:0] min_ontime_ns_i = 12'h000;
   logic [4:0] strap_level_i = 5'h00;
   logic [10:0] iout_amps_i = 11'h000;
   logic [8:0] temp_deg_i = 9'h000, vin_eighths_i = 9'h000;
   logic [1:0] pin_lvl = 2'h0;
   wire [1:0] voltage_id_pin_i, target_src_o;
   wire [15:0] rdata_o;
   wire ack_o, balance_hold_o, ontime_range_err_o, temp_offset_sign_o;
   wire output_current_status_o, temp_status_o, input_uv_status_o;
   wire shutdown_o;
   wire [9:0] balance_gain_o;
   wire [11:0] boot_mv_o, ontime_ns_o;
   wire [4:0] phase_two_offset_o, phase_three_offset_o, phase_four_offset_o;
   int fails = 0, tests_run = 0;
   logic [7:0] tbl [11] = '{8'h45, 8'h46, 8'h47, 8'h4a, 8'h4c, 8'h4d,
      8'h4e, 8'h51, 8'h55, 8'h58, 8'h60};
   logic [15:0] msk [11] = '{16'h07ff, 16'hffff, 16'hffff, 16'h03ff,
      16'h7fff, 16'h0000, 16'h0000, 16'h00ff, 16'he8ff, 16'he8ff, 16'h0000};
   int stp [4] = '{100, 50, 200, 100};
   int top [4] = '{1500, 1550, 3000, 3100};
   logic [1:0] src [4] = '{2'h2, 2'h0, 2'h1, 2'h0};
   int io_c [4] = '{101, 100, 150, 201};
   logic ex_c [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   vrcl_pin_drv vrcl_pin_drv_i (.level_i(pin_lvl), .voltage_id_pin_o(voltage_id_pin_i));
   vrcl_regs vrcl_regs_i (.clk_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i,
      .rdata_o, .ack_o, .voltage_id_pin_i, .softstart_active_i,
      .softstart_done_i, .phase_err_mv_i, .strap_level_i,
      .computed_ontime_ns_i, .min_ontime_ns_i, .total_current_res_i,
      .sample_i, .iout_amps_i, .temp_deg_i, .vin_eighths_i, .balance_hold_o,
      .balance_gain_o, .target_src_o, .boot_mv_o, .ontime_ns_o,
      .ontime_range_err_o, .phase_two_offset_o, .phase_three_offset_o,
      .phase_four_offset_o, .temp_offset_sign_o, .output_current_status_o,
      .temp_status_o, .input_uv_status_o, .shutdown_o);
   task end_of_test;
      $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One pulse strobe; ack is a single-cycle pulse, so no held request
   task access(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      @(negedge clk_i);
      wr_i = w;
      rd_i = !w;
      addr_i = a;
      wdata_i = d;
      @(negedge clk_i);
      wr_i = 0;
      rd_i = 0;
      for (n = 0; n < 4 && ack_o !== 1'b1; n++) @(negedge clk_i);
      if (ack_o !== 1'b1) begin
         fails++;
         end_of_test();
      end
      rd = rdata_o;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      access(1'b1, a, d);
      repeat (2) @(negedge clk_i);
   endtask
   task rd_chk(input logic [7:0] a, input logic [15:0] e);
      access(1'b0, a, 16'h0000);
      `CHK(rd, e)
   endtask
   task samp;
      @(negedge clk_i);
      sample_i = 1;
      @(negedge clk_i);
      sample_i = 0;
      @(negedge clk_i);
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 0;
      `CHK(balance_gain_o, 10'h01f)
      foreach (tbl[i]) begin
         rd_chk(tbl[i], (tbl[i] > 8'h54 && tbl[i] < 8'h59) ? 16'he800 : 0);
         wr(tbl[i], 16'hffff);
         rd_chk(tbl[i], msk[i]);
      end
      `CHK(temp_offset_sign_o, 1'b1)
      $display("Test registers done");
      wr(8'h4c, 16'h4d55);
      `CHK({phase_four_offset_o, phase_three_offset_o}, 10'h26a)
      `CHK(phase_two_offset_o, 5'h15)
      phase_err_mv_i = 12'h033;
      softstart_active_i = 1;
      for (int f = 0; f < 8; f++) begin
         wr(8'h45, 16'h0200 | 16'(f << 6));
         `CHK(balance_gain_o, 10'(f * 32 + 31))
      end
      `CHK(balance_hold_o, 1'b1)
      phase_err_mv_i = 12'h032;
      wr(8'h45, 16'h07c0);
      `CHK(balance_gain_o, 10'h01f)
      `CHK(balance_hold_o, 1'b0)
      $display("Test balance done");
      wr(8'h45, 16'h0020);
      for (int p = 0; p < 4; p++) begin
         pin_lvl = 2'(p);
         repeat (3) @(negedge clk_i);
         `CHK(target_src_o, src[p])
      end
      for (int t = 0; t < 4; t++) begin
         wr(8'h45, 16'h0004 | 16'(t));
         strap_level_i = 5'h05;
         repeat (2) @(negedge clk_i);
         `CHK(target_src_o, 2'h3)
         `CHK(boot_mv_o, 12'(stp[t] * 5))
         strap_level_i = 5'h1f;
         repeat (2) @(negedge clk_i);
         `CHK(boot_mv_o, 12'(top[t]))
      end
      softstart_done_i = 1;
      repeat (2) @(negedge clk_i);
      `CHK(target_src_o, 2'h0)
      computed_ontime_ns_i = 12'd50;
      min_ontime_ns_i = 12'd80;
      wr(8'h45, 16'h0010);
      `CHK(ontime_ns_o, 12'd80)
      wr(8'h45, 16'h0000);
      `CHK({ontime_range_err_o, ontime_ns_o}, 13'h1032)
      $display("Test boot and on time done");
      wr(8'h4a, 16'h0064);
      wr(8'h51, 16'h0050);
      wr(8'h58, 16'h0028);
      wr(8'h55, 16'h0064);
      for (int k = 0; k < 4; k++) begin
         total_current_res_i = k > 1;
         iout_amps_i = 11'(io_c[k]);
         temp_deg_i = 9'(80 + ex_c[k]);
         vin_eighths_i = 9'(40 - ex_c[k]);
         samp();
         `CHK(output_current_status_o, ex_c[k])
         `CHK(temp_status_o, ex_c[k])
         `CHK(input_uv_status_o, ex_c[k])
      end
      iout_amps_i = 11'h000;
      repeat (3) @(negedge clk_i);
      `CHK(output_current_status_o, 1'b1)
      vin_eighths_i = 9'd100;
      samp();
      `CHK(shutdown_o, 1'b0)
      vin_eighths_i = 9'd101;
      samp();
      vin_eighths_i = 9'd0;
      samp();
      `CHK(shutdown_o, 1'b1)
      $display("Test status done");
      end_of_test();
   end
endmodule
bind vrcl_regs vrcl_regs_chk vrcl_regs_chk_i (.clk_i, .rst_i, .wr_i, .rd_i,
   .ack_o, .softstart_active_i, .phase_err_mv_i, .computed_ontime_ns_i,
   .sample_i, .balance_gain_o, .balance_hold_o, .ontime_range_err_o,
   .output_current_status_o, .temp_status_o, .input_uv_status_o,
   .shutdown_o);
